/* File: pmbr_pkg.sv */
package pmbr_pkg;

	// Command codes
	localparam logic [7:0] CMD_OUTPUT_ON_OFF_CONTROL = 8'h01;
	localparam logic [7:0] CMD_ENABLE_SOURCE_CONFIG = 8'h02;
	localparam logic [7:0] CMD_FAULT_CLEAR_STROBE = 8'h03;
	localparam logic [7:0] CMD_WRITE_LOCK_LEVEL = 8'h10;
	localparam logic [7:0] CMD_PROTOCOL_FEATURE_SUMMARY = 8'h19;
	localparam logic [7:0] CMD_VOLTAGE_FORMAT_EXPONENT = 8'h20;
	localparam logic [7:0] CMD_REFERENCE_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_REFERENCE_UPPER_LIMIT = 8'h24;
	localparam logic [7:0] CMD_FAULT_SUMMARY_BYTE = 8'h78;
	localparam logic [7:0] CMD_FAULT_SUMMARY_WORD = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FAULTS = 8'h7A;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_FAULTS = 8'h7B;
	localparam logic [7:0] CMD_INPUT_VOLTAGE_FAULTS = 8'h7C;
	localparam logic [7:0] CMD_JUNCTION_TEMP_FAULTS = 8'h7D;
	localparam logic [7:0] CMD_LINK_ERROR_STATUS = 8'h7E;
	localparam logic [7:0] CMD_VENDOR_FAULT_STATUS = 8'h80;
	localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
	localparam logic [7:0] CMD_FEEDBACK_VOLTAGE_READING = 8'h8B;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_READING = 8'h8C;
	localparam logic [7:0] CMD_JUNCTION_TEMP_READING = 8'h8D;
	localparam logic [7:0] CMD_PART_IDENTITY_STRING = 8'hAD;
	localparam logic [7:0] CMD_REVISION_STRING = 8'hAE;
	localparam logic [7:0] CMD_STRAP_OVERRIDE_CONFIG = 8'hD0;
	localparam logic [7:0] CMD_LOOP_CONFIG_FIRST = 8'hD1;
	localparam logic [7:0] CMD_LOOP_CONFIG_SECOND = 8'hD2;
	localparam logic [7:0] CMD_LOOP_CONFIG_THIRD = 8'hD3;

	// Values after reset and fixed read values
	localparam logic [7:0] RST_OUTPUT_ON_OFF_CONTROL = 8'h80;
	localparam logic [7:0] RST_ENABLE_SOURCE_CONFIG = 8'h1F;
	localparam logic [7:0] RST_WRITE_LOCK_LEVEL = 8'h20;
	localparam logic [7:0] VAL_PROTOCOL_FEATURE_SUMMARY = 8'hC0;
	localparam logic [7:0] VAL_VOLTAGE_FORMAT_EXPONENT = 8'h17;
	localparam logic [15:0] RST_REFERENCE_SETPOINT = 16'h0100;
	localparam logic [15:0] RST_REFERENCE_UPPER_LIMIT = 16'h019A;
	localparam logic [7:0] RST_STRAP_OVERRIDE_CONFIG = 8'h00;
	localparam logic [7:0] RST_LOOP_CONFIG = 8'h00;

	// Setpoint range in 1.95 mV steps: 0.4 V and 0.8 V
	localparam logic [15:0] SETPOINT_MIN = 16'h00CD;
	localparam logic [15:0] SETPOINT_MAX = 16'h0199;

	// Target address base; strap code low three bits add on
	localparam logic [6:0] ADDR_BASE = 7'h30;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Write lock levels
	localparam int WL_ALL = 7;
	localparam int WL_OP = 6;
	localparam int WL_SET = 5;

	// Enable source configuration fields; on bit of on/off control
	localparam int ESC_USE = 4;
	localparam int ESC_OP = 3;
	localparam int ESC_PIN = 2;
	localparam int ESC_POL = 1;
	localparam int OP_ON = 7;

	// Link error bits
	localparam int LE_BAD_CMD = 7;
	localparam int LE_BAD_DATA = 6;

	// Serial engine states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b011,
		ST_RXB = 3'b010,
		ST_RACK = 3'b110,
		ST_TXB = 3'b111,
		ST_TACK = 3'b101
	} pmbr_state_e;

endpackage

/* File: pmbr_responder.sv */
`timescale 1ns/1ns
module pmbr_responder import pmbr_pkg::*; #(
	// Identity strings; values arbitrary
	parameter int ID_LEN = 8,
	parameter logic [63:0] ID_STR = 64'h5245_4755_4C41_5431,
	parameter int REV_LEN = 2,
	parameter logic [15:0] REV_STR = 16'h4131
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic EN_PIN,
	input wire logic [4:0] FIRST_PROGRAM_PIN_CODE,
	input wire logic [4:0] PGM1_CODE,
	input wire logic [7:0] VOUT_FLT,
	input wire logic [7:0] IOUT_FLT,
	input wire logic [7:0] INPUT_FLT,
	input wire logic [7:0] TEMP_FLT,
	input wire logic [7:0] MFR_FLT,
	input wire logic [15:0] VIN_READING,
	input wire logic [15:0] VFB_READING,
	input wire logic [15:0] IOUT_READING,
	input wire logic [15:0] TEMP_READING,
	output logic OUTPUT_ON,
	output logic [15:0] REF_SETPOINT,
	output logic STRAP_DONE,
	output logic [1:0] CURRENT_LIMIT_SEL,
	output logic [4:0] PGM1_STRAP,
	output logic [7:0] STRAP_OVERRIDE,
	output logic [7:0] SLOPE_COMP_AMPLITUDE,
	output logic [7:0] LOOP_CONFIG2,
	output logic [7:0] LOOP_CONFIG3
);

	// Known command codes
	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			CMD_OUTPUT_ON_OFF_CONTROL, CMD_ENABLE_SOURCE_CONFIG, CMD_FAULT_CLEAR_STROBE,
			CMD_WRITE_LOCK_LEVEL, CMD_PROTOCOL_FEATURE_SUMMARY, CMD_VOLTAGE_FORMAT_EXPONENT,
			CMD_REFERENCE_SETPOINT, CMD_REFERENCE_UPPER_LIMIT, CMD_FAULT_SUMMARY_BYTE,
			CMD_FAULT_SUMMARY_WORD, CMD_OUTPUT_VOLTAGE_FAULTS, CMD_OUTPUT_CURRENT_FAULTS,
			CMD_INPUT_VOLTAGE_FAULTS, CMD_JUNCTION_TEMP_FAULTS, CMD_LINK_ERROR_STATUS,
			CMD_VENDOR_FAULT_STATUS, CMD_INPUT_VOLTAGE_READING, CMD_FEEDBACK_VOLTAGE_READING,
			CMD_OUTPUT_CURRENT_READING, CMD_JUNCTION_TEMP_READING, CMD_PART_IDENTITY_STRING,
			CMD_REVISION_STRING, CMD_STRAP_OVERRIDE_CONFIG, CMD_LOOP_CONFIG_FIRST,
			CMD_LOOP_CONFIG_SECOND, CMD_LOOP_CONFIG_THIRD: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction

	// Data bytes a write carries; zero means not writable, except the bare fault clear
	function automatic logic [1:0] cmd_wr_len(input logic [7:0] c);
		case (c)
			CMD_OUTPUT_ON_OFF_CONTROL, CMD_ENABLE_SOURCE_CONFIG, CMD_WRITE_LOCK_LEVEL,
			CMD_STRAP_OVERRIDE_CONFIG, CMD_LOOP_CONFIG_FIRST, CMD_LOOP_CONFIG_SECOND,
			CMD_LOOP_CONFIG_THIRD: cmd_wr_len = 2'd1;
			CMD_REFERENCE_SETPOINT, CMD_REFERENCE_UPPER_LIMIT: cmd_wr_len = 2'd2;
			default: cmd_wr_len = 2'd0;
		endcase
	endfunction

	// Write lock filter; the lock byte itself is always writable
	function automatic logic lock_allows(input logic [7:0] c, input logic [7:0] wl);
		logic base;
		base = (c == CMD_WRITE_LOCK_LEVEL);
		if (wl[WL_ALL])
			lock_allows = base;
		else if (wl[WL_OP])
			lock_allows = base || c == CMD_OUTPUT_ON_OFF_CONTROL || c == CMD_FAULT_CLEAR_STROBE;
		else if (wl[WL_SET])
			lock_allows = base || c == CMD_OUTPUT_ON_OFF_CONTROL || c == CMD_FAULT_CLEAR_STROBE
				|| c == CMD_ENABLE_SOURCE_CONFIG || c == CMD_REFERENCE_SETPOINT;
		else
			lock_allows = 1'b1;
	endfunction

	// Clamp a setpoint into the legal window and under the limit
	function automatic logic [15:0] clamp_ref(input logic [15:0] v, input logic [15:0] lim);
		logic [15:0] top;
		top = (lim < SETPOINT_MAX) ? lim : SETPOINT_MAX;
		if (v > top)
			clamp_ref = top;
		else if (v < SETPOINT_MIN)
			clamp_ref = SETPOINT_MIN;
		else
			clamp_ref = v;
	endfunction

	logic scl_s1_q, scl_s2_q, scl_s3_q; // Clock line synchroniser and history
	logic sda_s1_q, sda_s2_q, sda_s3_q; // Data line synchroniser and history
	logic en_s1_q, en_s2_q; // Enable pin synchroniser
	logic [4:0] first_program_pin_s1_q, first_program_pin_s2_q, pgm1_s1_q, pgm1_s2_q; // Strap code synchronisers
	logic [1:0] settle_q; // Strap settling count
	logic strap_done_q; // Strap captured
	logic [6:0] dev_addr_q; // Own target address
	pmbr_state_e state_q; // Serial engine state
	logic [3:0] bit_cnt_q; // Bits of current byte
	logic [7:0] rx_sh_q; // Receive shifter
	logic [7:0] tx_sh_q; // Transmit shifter
	logic ack_q; // Host acknowledge, high means stop sending
	logic oe_q; // Pull the data line low
	logic wr_txn_q; // Write transaction in progress
	logic [1:0] rx_idx_q; // Bytes received after address
	logic [7:0] tx_idx_q; // Bytes sent in this read
	logic [7:0] cmd_q, data_lo_q, data_hi_q; // Latched command and data
	logic [7:0] op_q, esc_q, wl_q; // Control bytes
	logic [15:0] setpoint_q, limit_q; // Setpoint and its upper limit
	logic [7:0] strap_ovr_q, loop1_q, loop2_q, loop3_q; // Configuration bytes
	logic [7:0] vout_q, iout_q, input_q, temp_q, mfr_q, link_q; // Sticky faults
	logic on_q; // Output enable
	logic [15:0] ref_q; // Setpoint in use
	logic [7:0] tx_byte; // Byte to send next

	// Line events from synchronised levels only
	logic rise, fall, start_ev, stop_ev;
	assign rise = scl_s2_q && !scl_s3_q;
	assign fall = !scl_s2_q && scl_s3_q;
	assign start_ev = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
	assign stop_ev = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

	// Byte completion in the receive phase
	logic byte_done, cmd_byte, data_byte;
	assign byte_done = fall && state_q == ST_RXB && bit_cnt_q == 4'd8;
	assign cmd_byte = byte_done && rx_idx_q == 2'd0;
	assign data_byte = byte_done && rx_idx_q != 2'd0;

	// Stop-time decision on a write
	logic commit, len_ok, do_write, do_clear, bad_cmd, bad_data;
	assign commit = stop_ev && wr_txn_q && rx_idx_q != 2'd0;
	assign len_ok = rx_idx_q == cmd_wr_len(cmd_q) + 2'd1;
	assign do_write = commit && cmd_wr_len(cmd_q) != 2'd0 && len_ok && lock_allows(cmd_q, wl_q);
	assign do_clear = commit && cmd_q == CMD_FAULT_CLEAR_STROBE && rx_idx_q == 2'd1
		&& lock_allows(cmd_q, wl_q);
	assign bad_cmd = cmd_byte && !cmd_known(rx_sh_q);
	assign bad_data = (data_byte && cmd_wr_len(cmd_q) == 2'd0)
		|| (commit && cmd_known(cmd_q) && !do_write && !do_clear);

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge MCLK) begin
		if (RST) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			first_program_pin_s1_q <= 5'h00;
			first_program_pin_s2_q <= 5'h00;
			pgm1_s1_q <= 5'h00;
			pgm1_s2_q <= 5'h00;
		end else if (CE) begin
			scl_s1_q <= SCL_IN;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= SDA_IN;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			en_s1_q <= EN_PIN;
			en_s2_q <= en_s1_q;
			first_program_pin_s1_q <= FIRST_PROGRAM_PIN_CODE;
			first_program_pin_s2_q <= first_program_pin_s1_q;
			pgm1_s1_q <= PGM1_CODE;
			pgm1_s2_q <= pgm1_s1_q;
		end
	end

	// Strap capture, once, after the synchronisers have filled
	always_ff @(posedge MCLK) begin
		if (RST) begin
			settle_q <= 2'h0;
			strap_done_q <= 1'b0;
			dev_addr_q <= ADDR_BASE;
			CURRENT_LIMIT_SEL <= 2'h0;
			PGM1_STRAP <= 5'h00;
		end else if (CE && !strap_done_q) begin
			if (settle_q != STRAP_SETTLE) begin
				settle_q <= settle_q + 2'h1;
			end else begin
				strap_done_q <= 1'b1;
				dev_addr_q <= ADDR_BASE | {4'h0, first_program_pin_s2_q[2:0]};
				CURRENT_LIMIT_SEL <= first_program_pin_s2_q[4:3];
				PGM1_STRAP <= pgm1_s2_q;
			end
		end
	end

	// Serial engine: framing, address, byte shifting, acknowledge
	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			rx_sh_q <= 8'h00;
			tx_sh_q <= 8'h00;
			ack_q <= 1'b0;
			oe_q <= 1'b0;
			wr_txn_q <= 1'b0;
			rx_idx_q <= 2'h0;
			tx_idx_q <= 8'h00;
		end else if (CE) begin
			if (stop_ev) begin
				// Stop ends everything
				state_q <= ST_IDLE;
				oe_q <= 1'b0;
				wr_txn_q <= 1'b0;
			end else if (start_ev) begin
				// Start or repeated start; command byte is kept
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				oe_q <= 1'b0;
				tx_idx_q <= 8'h00;
			end else if (rise) begin
				// Sample on rising clock
				case (state_q)
					ST_ADDR, ST_RXB: begin
						rx_sh_q <= {rx_sh_q[6:0], sda_s2_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					ST_TXB: bit_cnt_q <= bit_cnt_q + 4'h1;
					ST_TACK: ack_q <= sda_s2_q;
					default: ;
				endcase
			end else if (fall) begin
				// Drive on falling clock
				case (state_q)
					ST_ADDR: begin
						if (bit_cnt_q == 4'd8) begin
							if (strap_done_q && rx_sh_q[7:1] == dev_addr_q) begin
								state_q <= ST_AACK;
								oe_q <= 1'b1;
								wr_txn_q <= !rx_sh_q[0];
								if (!rx_sh_q[0])
									rx_idx_q <= 2'h0;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_AACK: begin
						bit_cnt_q <= 4'h0;
						if (wr_txn_q) begin
							state_q <= ST_RXB;
							oe_q <= 1'b0;
						end else begin
							// First read byte, MSB out at once
							state_q <= ST_TXB;
							tx_sh_q <= tx_byte;
							oe_q <= !tx_byte[7];
							tx_idx_q <= tx_idx_q + 8'h01;
						end
					end
					ST_RXB: begin
						if (bit_cnt_q == 4'd8) begin
							state_q <= ST_RACK;
							oe_q <= 1'b1;
							if (rx_idx_q != 2'h3)
								rx_idx_q <= rx_idx_q + 2'h1;
						end
					end
					ST_RACK: begin
						state_q <= ST_RXB;
						oe_q <= 1'b0;
						bit_cnt_q <= 4'h0;
					end
					ST_TXB: begin
						if (bit_cnt_q == 4'd8) begin
							state_q <= ST_TACK;
							oe_q <= 1'b0;
						end else begin
							tx_sh_q <= {tx_sh_q[6:0], 1'b0};
							oe_q <= !tx_sh_q[6];
						end
					end
					ST_TACK: begin
						// Host not acknowledging ends the read
						if (ack_q) begin
							state_q <= ST_IDLE;
						end else begin
							state_q <= ST_TXB;
							bit_cnt_q <= 4'h0;
							tx_sh_q <= tx_byte;
							oe_q <= !tx_byte[7];
							tx_idx_q <= tx_idx_q + 8'h01;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Command and data capture
	always_ff @(posedge MCLK) begin
		if (RST) begin
			cmd_q <= 8'h00;
			data_lo_q <= 8'h00;
			data_hi_q <= 8'h00;
		end else if (CE && byte_done) begin
			case (rx_idx_q)
				2'h0: cmd_q <= rx_sh_q;
				2'h1: data_lo_q <= rx_sh_q;
				2'h2: data_hi_q <= rx_sh_q;
				default: ;
			endcase
		end
	end

	// Writable registers; a write lands only at a clean stop
	always_ff @(posedge MCLK) begin
		if (RST) begin
			op_q <= RST_OUTPUT_ON_OFF_CONTROL;
			esc_q <= RST_ENABLE_SOURCE_CONFIG;
			wl_q <= RST_WRITE_LOCK_LEVEL;
			setpoint_q <= RST_REFERENCE_SETPOINT;
			limit_q <= RST_REFERENCE_UPPER_LIMIT;
			strap_ovr_q <= RST_STRAP_OVERRIDE_CONFIG;
			loop1_q <= RST_LOOP_CONFIG;
			loop2_q <= RST_LOOP_CONFIG;
			loop3_q <= RST_LOOP_CONFIG;
		end else if (CE && do_write) begin
			case (cmd_q)
				CMD_OUTPUT_ON_OFF_CONTROL: op_q <= data_lo_q;
				CMD_ENABLE_SOURCE_CONFIG: esc_q <= data_lo_q;
				CMD_WRITE_LOCK_LEVEL: wl_q <= data_lo_q;
				CMD_REFERENCE_SETPOINT: setpoint_q <= clamp_ref({data_hi_q, data_lo_q}, limit_q);
				CMD_REFERENCE_UPPER_LIMIT: limit_q <= {data_hi_q, data_lo_q};
				CMD_STRAP_OVERRIDE_CONFIG: strap_ovr_q <= data_lo_q;
				CMD_LOOP_CONFIG_FIRST: loop1_q <= data_lo_q;
				CMD_LOOP_CONFIG_SECOND: loop2_q <= data_lo_q;
				CMD_LOOP_CONFIG_THIRD: loop3_q <= data_lo_q;
				default: ;
			endcase
		end
	end

	// Sticky faults; a new event beats a clear in the same cycle
	always_ff @(posedge MCLK) begin
		if (RST) begin
			vout_q <= 8'h00;
			iout_q <= 8'h00;
			input_q <= 8'h00;
			temp_q <= 8'h00;
			mfr_q <= 8'h00;
			link_q <= 8'h00;
		end else if (CE) begin
			vout_q <= (do_clear ? 8'h00 : vout_q) | VOUT_FLT;
			iout_q <= (do_clear ? 8'h00 : iout_q) | IOUT_FLT;
			input_q <= (do_clear ? 8'h00 : input_q) | INPUT_FLT;
			temp_q <= (do_clear ? 8'h00 : temp_q) | TEMP_FLT;
			mfr_q <= (do_clear ? 8'h00 : mfr_q) | MFR_FLT;
			link_q <= (do_clear ? 8'h00 : link_q) | {bad_cmd, bad_data, 6'h00};
		end
	end

	// Output enable and applied setpoint
	always_ff @(posedge MCLK) begin
		if (RST) begin
			on_q <= 1'b0;
			ref_q <= RST_REFERENCE_SETPOINT;
		end else if (CE) begin
			if (!esc_q[ESC_USE])
				on_q <= 1'b1;
			else
				on_q <= (!esc_q[ESC_OP] || op_q[OP_ON])
					&& (!esc_q[ESC_PIN] || en_s2_q == esc_q[ESC_POL]);
			// A lowered limit pulls the live setpoint down too
			ref_q <= clamp_ref(setpoint_q, limit_q);
		end
	end

	// Read data for the byte about to be sent
	always_comb begin
		logic [7:0] k;
		k = tx_idx_q - 8'h01;
		tx_byte = 8'hFF;
		case (cmd_q)
			CMD_OUTPUT_ON_OFF_CONTROL: tx_byte = op_q;
			CMD_ENABLE_SOURCE_CONFIG: tx_byte = esc_q;
			CMD_WRITE_LOCK_LEVEL: tx_byte = wl_q;
			CMD_PROTOCOL_FEATURE_SUMMARY: tx_byte = VAL_PROTOCOL_FEATURE_SUMMARY;
			CMD_VOLTAGE_FORMAT_EXPONENT: tx_byte = VAL_VOLTAGE_FORMAT_EXPONENT;
			CMD_REFERENCE_SETPOINT: tx_byte = tx_idx_q[0] ? setpoint_q[15:8] : setpoint_q[7:0];
			CMD_REFERENCE_UPPER_LIMIT: tx_byte = tx_idx_q[0] ? limit_q[15:8] : limit_q[7:0];
			CMD_FAULT_SUMMARY_BYTE: tx_byte = {1'b0, !on_q, vout_q[7], iout_q[7], input_q[4],
				|temp_q, |link_q, |mfr_q};
			CMD_FAULT_SUMMARY_WORD: tx_byte = tx_idx_q[0] ? {|vout_q, |iout_q, |input_q, |mfr_q, 4'h0}
				: {1'b0, !on_q, vout_q[7], iout_q[7], input_q[4], |temp_q, |link_q, |mfr_q};
			CMD_OUTPUT_VOLTAGE_FAULTS: tx_byte = vout_q;
			CMD_OUTPUT_CURRENT_FAULTS: tx_byte = iout_q;
			CMD_INPUT_VOLTAGE_FAULTS: tx_byte = input_q;
			CMD_JUNCTION_TEMP_FAULTS: tx_byte = temp_q;
			CMD_VENDOR_FAULT_STATUS: tx_byte = mfr_q;
			CMD_LINK_ERROR_STATUS: tx_byte = link_q;
			CMD_INPUT_VOLTAGE_READING: tx_byte = tx_idx_q[0] ? VIN_READING[15:8] : VIN_READING[7:0];
			CMD_FEEDBACK_VOLTAGE_READING: tx_byte = tx_idx_q[0] ? VFB_READING[15:8] : VFB_READING[7:0];
			CMD_OUTPUT_CURRENT_READING: tx_byte = tx_idx_q[0] ? IOUT_READING[15:8] : IOUT_READING[7:0];
			CMD_JUNCTION_TEMP_READING: tx_byte = tx_idx_q[0] ? TEMP_READING[15:8] : TEMP_READING[7:0];
			CMD_PART_IDENTITY_STRING: begin
				if (tx_idx_q == 8'h00)
					tx_byte = 8'(ID_LEN);
				else if (k < 8'(ID_LEN))
					tx_byte = ID_STR[8 * (ID_LEN - 1 - int'(k)) +: 8];
			end
			CMD_REVISION_STRING: begin
				if (tx_idx_q == 8'h00)
					tx_byte = 8'(REV_LEN);
				else if (k < 8'(REV_LEN))
					tx_byte = REV_STR[8 * (REV_LEN - 1 - int'(k)) +: 8];
			end
			CMD_STRAP_OVERRIDE_CONFIG: tx_byte = strap_ovr_q;
			CMD_LOOP_CONFIG_FIRST: tx_byte = loop1_q;
			CMD_LOOP_CONFIG_SECOND: tx_byte = loop2_q;
			CMD_LOOP_CONFIG_THIRD: tx_byte = loop3_q;
			default: tx_byte = 8'hFF;
		endcase
	end

	// Open-drain data line: only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE = oe_q;
	assign OUTPUT_ON = on_q;
	assign REF_SETPOINT = ref_q;
	assign STRAP_DONE = strap_done_q;
	assign STRAP_OVERRIDE = strap_ovr_q;
	assign SLOPE_COMP_AMPLITUDE = loop1_q;
	assign LOOP_CONFIG2 = loop2_q;
	assign LOOP_CONFIG3 = loop3_q;

endmodule

/* File: pmbr_checker.sv */
`timescale 1ns/1ns
module pmbr_checker import pmbr_pkg::*; (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SCL_IN,
	input wire logic [4:0] FIRST_PROGRAM_PIN_CODE,
	input wire logic [4:0] PGM1_CODE,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic OUTPUT_ON,
	input wire logic [15:0] REF_SETPOINT,
	input wire logic STRAP_DONE,
	input wire logic [1:0] CURRENT_LIMIT_SEL,
	input wire logic [4:0] PGM1_STRAP,
	input wire logic [7:0] SLOPE_COMP_AMPLITUDE
);
	a_reset_state: assert property (@(posedge MCLK) RST |=> !SDA_OE && !OUTPUT_ON
		&& !STRAP_DONE && REF_SETPOINT == RST_REFERENCE_SETPOINT
		&& SLOPE_COMP_AMPLITUDE == RST_LOOP_CONFIG) else $error("reset state wrong");
	a_drain_only: assert property (@(posedge MCLK) SDA_OUT == 1'b0)
		else $error("data pin driven high");
	a_strap_map: assert property (@(posedge MCLK) disable iff (RST) $rose(STRAP_DONE) |->
		CURRENT_LIMIT_SEL == FIRST_PROGRAM_PIN_CODE[4:3] && PGM1_STRAP == PGM1_CODE)
		else $error("strap value wrong");
	a_strap_time: assert property (@(posedge MCLK) disable iff (RST) $fell(RST) |->
		!STRAP_DONE ##[1:6] STRAP_DONE) else $error("strap capture late");
	// straps kept; a later pin change must not leak in
	a_strap_keep: assert property (@(posedge MCLK) disable iff (RST) $past(STRAP_DONE) |->
		STRAP_DONE && $stable(CURRENT_LIMIT_SEL) && $stable(PGM1_STRAP))
		else $error("strap changed");
	a_ref_range: assert property (@(posedge MCLK) disable iff (RST)
		REF_SETPOINT >= SETPOINT_MIN && REF_SETPOINT <= SETPOINT_MAX) else $error("setpoint range");
	// answer moves in low phase only
	a_oe_low_phase: assert property (@(posedge MCLK) disable iff (RST) $changed(SDA_OE) |->
		!SCL_IN && !$past(SCL_IN)) else $error("data pin moved in high phase");
	a_oe_steady: assert property (@(posedge MCLK) disable iff (RST) SCL_IN [*8] |->
		$stable(SDA_OE)) else $error("data pin unstable");
	// Main scenarios reached
	c_ack: cover property (@(posedge MCLK) $rose(SDA_OE));
	c_strap: cover property (@(posedge MCLK) $rose(STRAP_DONE));
	c_ref: cover property (@(posedge MCLK) $changed(REF_SETPOINT));
endmodule
bind pmbr_responder pmbr_checker chk (.MCLK(MCLK), .RST(RST), .SCL_IN(SCL_IN),
	.FIRST_PROGRAM_PIN_CODE(FIRST_PROGRAM_PIN_CODE), .PGM1_CODE(PGM1_CODE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.OUTPUT_ON(OUTPUT_ON), .REF_SETPOINT(REF_SETPOINT), .STRAP_DONE(STRAP_DONE),
	.CURRENT_LIMIT_SEL(CURRENT_LIMIT_SEL), .PGM1_STRAP(PGM1_STRAP),
	.SLOPE_COMP_AMPLITUDE(SLOPE_COMP_AMPLITUDE));

/* File: pmbr_host.sv */
`timescale 1ns/1ns
module pmbr_host (
	input wire logic MCLK,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_pull
);
	// Half bit phase; responder needs eight clocks or more
	localparam int PH = 10;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge MCLK);
	endtask
	// Start or repeated start; data moves 2 clocks after the fall to avoid a false stop
	task automatic start();
		gap(2);
		sda_pull = 1'b0;
		gap(PH);
		scl = 1'b1;
		gap(PH);
		sda_pull = 1'b1;
		gap(PH);
		scl = 1'b0;
	endtask
	task automatic stop();
		gap(2);
		sda_pull = 1'b1;
		gap(PH);
		scl = 1'b1;
		gap(PH);
		sda_pull = 1'b0;
		gap(PH);
	endtask
	// Eight bits and ack, MSB first, sampled mid high phase
	task automatic xfer(input logic [8:0] wb, output logic [8:0] rb);
		for (int i = 8; i >= 0; i--) begin
			gap(2);
			sda_pull = !wb[i];
			gap(PH);
			scl = 1'b1;
			gap(PH / 2);
			rb[i] = sda_wire;
			gap(PH / 2);
			scl = 1'b0;
		end
	endtask
	// n of 0 sends a bare command
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n,
		input logic [15:0] d, output logic ack);
		logic [8:0] r;
		start();
		xfer({a, 1'b0, 1'b1}, r);
		ack = !r[0];
		xfer({c, 1'b1}, r);
		for (int i = 0; i < n; i++) begin
			xfer({d[8*i +: 8], 1'b1}, r);
		end
		stop();
	endtask
	// Read n bytes, low first, last one refused
	task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n, output logic [23:0] q);
		logic [8:0] r;
		q = '0;
		start();
		xfer({a, 1'b0, 1'b1}, r);
		xfer({c, 1'b1}, r);
		start();
		xfer({a, 1'b1, 1'b1}, r);
		for (int i = 0; i < n; i++) begin
			xfer({8'hFF, i == n - 1}, r);
			q[8*i +: 8] = r[8:1];
		end
		stop();
	endtask
endmodule

/* File: tb_pmbus_command_set_regulator.sv */
`timescale 1ns/1ns
module tb_pmbus_command_set_regulator import pmbr_pkg::*;;
	// Identity strings, values arbitrary
	localparam logic [63:0] ID_STR = 64'h4142_4344_4546_4748;
	localparam logic [15:0] REV_STR = 16'h3130;
	localparam logic [6:0] ADDR = 7'h35;
	localparam logic [39:0] FPAT = 40'h08_04_10_01_80;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic en_pin = 1'b1;
	logic [4:0] first_program_pin = 5'h15;
	logic [39:0] flt = '0;
	logic [63:0] tel = 64'hA1B2_C3D4_E5F6_0718;
	logic scl, sda_pull, sda_oe, output_on;
	logic [15:0] ref_sp;
	logic [1:0] ilim;
	logic [31:0] cfg;
	logic [23:0] q;
	logic ack;
	int fail_count = 0;
	int compares = 0;
	logic [7:0] rc [8] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h24, 8'hD1};
	logic [23:0] rv [8] = '{24'h80, 24'h1F, 24'h20, 24'hC0, 24'h17, 24'h100, 24'h19A, 24'h0};
	// Pull-up on the data line
	wire sda = !(sda_pull | sda_oe);
	pmbr_responder #(.ID_STR(ID_STR), .REV_STR(REV_STR)) dut (.MCLK(mclk), .RST(rst), .CE(1'b1),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .EN_PIN(en_pin),
		.FIRST_PROGRAM_PIN_CODE(first_program_pin), .PGM1_CODE(5'h09), .VOUT_FLT(flt[7:0]), .IOUT_FLT(flt[15:8]),
		.INPUT_FLT(flt[23:16]), .TEMP_FLT(flt[31:24]), .MFR_FLT(flt[39:32]),
		.VIN_READING(tel[15:0]), .VFB_READING(tel[31:16]), .IOUT_READING(tel[47:32]),
		.TEMP_READING(tel[63:48]), .OUTPUT_ON(output_on), .REF_SETPOINT(ref_sp),
		.STRAP_DONE(), .CURRENT_LIMIT_SEL(ilim), .PGM1_STRAP(), .STRAP_OVERRIDE(cfg[7:0]),
		.SLOPE_COMP_AMPLITUDE(cfg[15:8]), .LOOP_CONFIG2(cfg[23:16]), .LOOP_CONFIG3(cfg[31:24]));
	pmbr_host host (.MCLK(mclk), .sda_wire(sda), .scl(scl), .sda_pull(sda_pull));
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] c, input int n, input logic [23:0] e);
		host.rd(ADDR, c, n, q);
		chk(q, e);
	endtask
	task automatic stop_test();
		$display("mismatches %0d, comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard, above the roughly 47k clocks of traffic
	initial begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (12) @(negedge mclk);
		// Strap pin moves after capture; address must stay put
		first_program_pin = 5'h02;
		chk({22'h0, ilim}, 24'h2);
		for (int i = 0; i < 8; i++) begin
			rdc(rc[i], (rc[i] == 8'h21 || rc[i] == 8'h24) ? 2 : 1, rv[i]);
		end
		host.wr(7'h36, 8'h01, 1, 16'h0, ack);
		chk({22'h0, ack, output_on}, 24'h1);
		host.wr(ADDR, 8'h01, 1, 16'h0, ack);
		chk({22'h0, ack, output_on}, 24'h2);
		host.wr(ADDR, 8'h01, 1, 16'h80, ack);
		en_pin = 1'b0;
		repeat (6) @(negedge mclk);
		chk({23'h0, output_on}, 24'h0);
		host.wr(ADDR, 8'h02, 1, 16'h0, ack);
		chk({23'h0, output_on}, 24'h1);
		// Factory lock refuses the limit word
		host.wr(ADDR, 8'h24, 2, 16'h0150, ack);
		rdc(8'h24, 2, 24'h19A);
		rdc(8'h7E, 1, 24'h40);
		rdc(8'h78, 1, 24'h02);
		rdc(8'h79, 2, 24'h0002);
		host.wr(ADDR, 8'h03, 0, 16'h0, ack);
		rdc(8'h7E, 1, 24'h0);
		host.wr(ADDR, 8'h19, 1, 16'h55, ack);
		host.wr(ADDR, 8'hE5, 1, 16'h55, ack);
		rdc(8'h7E, 1, 24'hC0);
		rdc(8'h19, 1, 24'hC0);
		host.wr(ADDR, 8'h10, 1, 16'h0, ack);
		host.wr(ADDR, 8'h24, 2, 16'h0150, ack);
		host.wr(ADDR, 8'h21, 2, 16'h0180, ack);
		rdc(8'h24, 2, 24'h150);
		rdc(8'h21, 2, 24'h150);
		chk({8'h0, ref_sp}, 24'h150);
		host.wr(ADDR, 8'h21, 2, 16'h0010, ack);
		rdc(8'h21, 2, 24'h0CD);
		for (int i = 0; i < 4; i++) begin
			host.wr(ADDR, 8'hD0 | 8'(i), 1, 16'(i + 5'h11), ack);
			rdc(8'hD0 | 8'(i), 1, 24'(i + 5'h11));
			chk({16'h0, cfg[8*i +: 8]}, 24'(i + 5'h11));
		end
		host.wr(ADDR, 8'h03, 0, 16'h0, ack);
		// One-clock fault pulse must stick
		flt = FPAT;
		@(negedge mclk);
		flt = '0;
		for (int i = 0; i < 5; i++) begin
			rdc(i == 4 ? 8'h80 : 8'h7A + 8'(i), 1, 24'(FPAT[8*i +: 8]));
		end
		rdc(8'h78, 1, 24'h2D);
		rdc(8'h79, 2, 24'hF02D);
		host.wr(ADDR, 8'h03, 0, 16'h0, ack);
		rdc(8'h7A, 1, 24'h0);
		for (int i = 0; i < 4; i++) begin
			rdc(i == 0 ? 8'h88 : 8'h8A + 8'(i), 2, 24'(tel[16*i +: 16]));
		end
		rdc(8'hAD, 3, {ID_STR[55:48], ID_STR[63:56], 8'h08});
		rdc(8'hAE, 3, {REV_STR[7:0], REV_STR[15:8], 8'h02});
		stop_test();
	end
endmodule
